// ===== verilog/scsm_core.v
// Safety communication state machine with AXI4-Lite register access
`timescale 1ns/100ps
`include "scsm_consts.vh"

// Functional notes
// - Ack request state: ack rising edge with no errors goes Operational.
// - Ack request state: fail-value command at 1 goes to passivation with command.
// - Passivation with command: command at 0 and ack request set goes to ack request.
// - Passivation with command: fatal self-test failure goes to fail-safe.
// - Passivation with command: power cycle or reboot returns to start-up.
// - Passivation with command: no error and command at 0 goes Operational.
// - Reintegration: watchdog expiry or communication error goes to module passivation.
// - Reintegration: fail-value command at 1 goes to passivation with command.
// - Ack request: ack edge while errors remain goes to reintegration.
// - Passivation with command: command 0 with errors pending goes to reintegration.
// - Any state, motor stopped: configuration tool connection enters configuration.
// - Configuration leaves only to start-up, on power cycle or reboot.
// - Reply frame built within 50 ms of safety frame reception.
// - Worst-case delay and device watchdog are both 50 ms.
// - Passivation cleared, command 0: raise ack request and enter ack request state.
// - Operational: safety function problem goes to reintegration.
// - Reintegration returns Operational only when all errors solved and acknowledged.
// - Operational: watchdog expiry or communication error goes to module passivation.
module scsm_core #(
  parameter WD_CYCLES  = (`SCSM_DEV_WD_MS * `SCSM_CLK_KHZ),
  parameter ACK_CYCLES = (`SCSM_ACK_TIME_MS * `SCSM_CLK_KHZ)
) (
  input  wire        CORE_CLK,
  input  wire        RESET,
  input  wire [11:0] S_AXI_AWADDR,
  input  wire        S_AXI_AWVALID,
  output wire        S_AXI_AWREADY,
  input  wire [31:0] S_AXI_WDATA,
  input  wire [3:0]  S_AXI_WSTRB,
  input  wire        S_AXI_WVALID,
  output wire        S_AXI_WREADY,
  output reg  [1:0]  S_AXI_BRESP,
  output reg         S_AXI_BVALID,
  input  wire        S_AXI_BREADY,
  input  wire [11:0] S_AXI_ARADDR,
  input  wire        S_AXI_ARVALID,
  output wire        S_AXI_ARREADY,
  output reg  [31:0] S_AXI_RDATA,
  output reg  [1:0]  S_AXI_RRESP,
  output reg         S_AXI_RVALID,
  input  wire        S_AXI_RREADY,
  output reg  [2:0]  SAFETY_STATE,
  output reg         OPERATOR_ACK_REQUEST,
  output reg         REPLY_FRAME_STROBE,
  output reg         WATCHDOG_EXPIRED
);

  localparam [2:0] ST_STARTUP  = `SCSM_ST_STARTUP;
  localparam [2:0] ST_OPER     = `SCSM_ST_OPER;
  localparam [2:0] ST_PASSIV   = `SCSM_ST_PASSIV;
  localparam [2:0] ST_PASCMD   = `SCSM_ST_PASCMD;
  localparam [2:0] ST_REINT    = `SCSM_ST_REINT;
  localparam [2:0] ST_ACKREQ   = `SCSM_ST_ACKREQ;
  localparam [2:0] ST_FAILSAFE = `SCSM_ST_FAILSAFE;
  localparam [2:0] ST_CONFIG   = `SCSM_ST_CONFIG;

  // AXI write side
  reg  [11:0] aw_addr_reg;
  reg         aw_held_reg;
  reg  [31:0] w_data_reg;
  reg  [3:0]  w_strb_reg;
  reg         w_held_reg;
  reg  [7:0]  ctrl_reg;
  reg  [31:0] wd_time_reg;
  reg         frame_oa_reg;
  reg         frame_fv_reg;
  reg         frame_pulse_reg;
  reg         wd_time_pulse_reg;
  reg         reboot_pulse_reg;
  wire        do_write;

  // Machine side
  reg  [2:0]  state_reg;
  reg  [2:0]  state_next;
  reg         ack_req_next;
  reg         oa_prev_reg;
  reg         fv_reg;
  reg  [31:0] wd_count_reg;
  reg  [31:0] ack_count_reg;
  reg         reply_pending_reg;
  reg         comm_err_reg;
  wire        oa_edge;
  wire        wd_fault;
  wire        errors_pending;
  wire        fatal;
  wire        cfg_entry;

  function addr_hit;
    input [11:0] addr;
    input [11:0] offset;
    begin
      addr_hit = (addr[11:2] == offset[11:2]);
    end
  endfunction

  function mapped;
    input [11:0] addr;
    begin
      mapped = addr_hit(addr, `SCSM_OFF_CTRL) | addr_hit(addr, `SCSM_OFF_STATUS) |
               addr_hit(addr, `SCSM_OFF_FRAME) | addr_hit(addr, `SCSM_OFF_WDTIME);
    end
  endfunction

  assign S_AXI_AWREADY = ~aw_held_reg & ~S_AXI_BVALID;
  assign S_AXI_WREADY  = ~w_held_reg & ~S_AXI_BVALID;
  assign S_AXI_ARREADY = ~S_AXI_RVALID;
  assign do_write      = aw_held_reg & w_held_reg & ~S_AXI_BVALID;

  // Address and data are taken in either order and answered once both are in
  always @(posedge CORE_CLK) begin
    if (RESET) begin
      aw_held_reg       <= 1'b0;
      w_held_reg        <= 1'b0;
      aw_addr_reg       <= 12'h000;
      w_data_reg        <= 32'h0000_0000;
      w_strb_reg        <= 4'h0;
      S_AXI_BVALID      <= 1'b0;
      S_AXI_BRESP       <= `SCSM_RESP_OKAY;
      ctrl_reg          <= 8'h00;
      wd_time_reg       <= 32'h0000_0000;
      frame_oa_reg      <= 1'b0;
      frame_fv_reg      <= 1'b0;
      frame_pulse_reg   <= 1'b0;
      wd_time_pulse_reg <= 1'b0;
      reboot_pulse_reg  <= 1'b0;
    end else begin
      frame_pulse_reg   <= 1'b0;
      wd_time_pulse_reg <= 1'b0;
      reboot_pulse_reg  <= 1'b0;
      if (S_AXI_AWVALID && S_AXI_AWREADY) begin
        aw_held_reg <= 1'b1;
        aw_addr_reg <= S_AXI_AWADDR;
      end
      if (S_AXI_WVALID && S_AXI_WREADY) begin
        w_held_reg <= 1'b1;
        w_data_reg <= S_AXI_WDATA;
        w_strb_reg <= S_AXI_WSTRB;
      end
      if (do_write) begin
        aw_held_reg  <= 1'b0;
        w_held_reg   <= 1'b0;
        S_AXI_BVALID <= 1'b1;
        S_AXI_BRESP  <= mapped(aw_addr_reg) ? `SCSM_RESP_OKAY : `SCSM_RESP_SLVERR;
        if (addr_hit(aw_addr_reg, `SCSM_OFF_CTRL) && w_strb_reg[0]) begin
          // Reboot bit is a command, never stored
          ctrl_reg         <= w_data_reg[7:0] & 8'hFE;
          reboot_pulse_reg <= w_data_reg[`SCSM_CTRL_REBOOT];
        end
        if (addr_hit(aw_addr_reg, `SCSM_OFF_FRAME) && w_strb_reg[0]) begin
          frame_oa_reg    <= w_data_reg[`SCSM_FRM_OA];
          frame_fv_reg    <= w_data_reg[`SCSM_FRM_FV];
          frame_pulse_reg <= 1'b1;
        end
        if (addr_hit(aw_addr_reg, `SCSM_OFF_WDTIME)) begin
          wd_time_reg       <= w_data_reg;
          wd_time_pulse_reg <= 1'b1;
        end
      end else if (S_AXI_BVALID && S_AXI_BREADY) begin
        S_AXI_BVALID <= 1'b0;
      end
    end
  end

  // Read side answers one cycle after the address is taken
  // Status packs the state, both flags and the commands of the last frame
  always @(posedge CORE_CLK) begin
    if (RESET) begin
      S_AXI_RVALID <= 1'b0;
      S_AXI_RDATA  <= 32'h0000_0000;
      S_AXI_RRESP  <= `SCSM_RESP_OKAY;
    end else if (S_AXI_ARVALID && S_AXI_ARREADY) begin
      S_AXI_RVALID <= 1'b1;
      S_AXI_RRESP  <= mapped(S_AXI_ARADDR) ? `SCSM_RESP_OKAY : `SCSM_RESP_SLVERR;
      if (addr_hit(S_AXI_ARADDR, `SCSM_OFF_CTRL))
        S_AXI_RDATA <= {24'h00_0000, ctrl_reg};
      else if (addr_hit(S_AXI_ARADDR, `SCSM_OFF_STATUS))
        S_AXI_RDATA <= {24'h00_0000, fv_reg, oa_prev_reg, WATCHDOG_EXPIRED,
                        OPERATOR_ACK_REQUEST, 1'b0, state_reg};
      else if (addr_hit(S_AXI_ARADDR, `SCSM_OFF_FRAME))
        S_AXI_RDATA <= {30'h0000_0000, frame_fv_reg, frame_oa_reg};
      else if (addr_hit(S_AXI_ARADDR, `SCSM_OFF_WDTIME))
        S_AXI_RDATA <= wd_time_reg;
      else
        S_AXI_RDATA <= 32'h0000_0000;
    end else if (S_AXI_RVALID && S_AXI_RREADY) begin
      S_AXI_RVALID <= 1'b0;
    end
  end

  // Edge test weighs the frame just taken against the one kept from before
  assign oa_edge        = frame_pulse_reg & frame_oa_reg & ~oa_prev_reg;
  assign wd_fault       = comm_err_reg | WATCHDOG_EXPIRED;
  assign errors_pending = ctrl_reg[`SCSM_CTRL_SFERR] | ctrl_reg[`SCSM_CTRL_SFACK];
  assign fatal          = ctrl_reg[`SCSM_CTRL_FATAL];
  assign cfg_entry      = ctrl_reg[`SCSM_CTRL_CFGTOOL] & ~ctrl_reg[`SCSM_CTRL_MOTOR];

  always @* begin
    state_next   = state_reg;
    ack_req_next = OPERATOR_ACK_REQUEST;
    if (reboot_pulse_reg) begin
      state_next   = ST_STARTUP;
      ack_req_next = 1'b0;
    end else if (cfg_entry) begin
      state_next   = ST_CONFIG;
    end else begin
      case (state_reg)
        ST_STARTUP: begin
          // Frames taken here only record the host's commands
          if (fatal)
            state_next = ST_FAILSAFE;
          else if (ctrl_reg[`SCSM_CTRL_BOOTOK])
            state_next = ST_PASCMD;
        end
        ST_OPER: begin
          if (fatal)
            state_next = ST_FAILSAFE;
          else if (wd_fault)
            state_next = ST_PASSIV;
          else if (fv_reg)
            state_next = ST_PASCMD;
          else if (ctrl_reg[`SCSM_CTRL_SFERR])
            state_next = ST_REINT;
        end
        ST_PASSIV: begin
          if (fatal)
            state_next = ST_FAILSAFE;
          else if (!wd_fault && fv_reg)
            state_next = ST_PASCMD;
          else if (!wd_fault) begin
            state_next   = ST_ACKREQ;
            ack_req_next = 1'b1;
          end
        end
        ST_PASCMD: begin
          if (fatal)
            state_next = ST_FAILSAFE;
          else if (wd_fault)
            state_next = ST_PASSIV;
          else if (!fv_reg && OPERATOR_ACK_REQUEST)
            state_next = ST_ACKREQ;
          else if (!fv_reg && errors_pending)
            state_next = ST_REINT;
          else if (!fv_reg)
            state_next = ST_OPER;
        end
        ST_REINT: begin
          if (fatal)
            state_next = ST_FAILSAFE;
          else if (wd_fault)
            state_next = ST_PASSIV;
          else if (fv_reg)
            state_next = ST_PASCMD;
          else if (!errors_pending)
            state_next = ST_OPER;
        end
        ST_ACKREQ: begin
          if (fatal)
            state_next = ST_FAILSAFE;
          else if (wd_fault)
            state_next = ST_PASSIV;
          else if (fv_reg)
            state_next = ST_PASCMD;
          else if (oa_edge && errors_pending) begin
            state_next   = ST_REINT;
            ack_req_next = 1'b0;
          end else if (oa_edge) begin
            state_next   = ST_OPER;
            ack_req_next = 1'b0;
          end
        end
        // Fail-safe is left by reboot or by configuration entry; configuration only by reboot
        ST_FAILSAFE: state_next = ST_FAILSAFE;
        ST_CONFIG:   state_next = ST_CONFIG;
        default:     state_next = ST_STARTUP;
      endcase
    end
  end

  always @(posedge CORE_CLK) begin
    if (RESET) begin
      state_reg            <= ST_STARTUP;
      SAFETY_STATE         <= ST_STARTUP;
      OPERATOR_ACK_REQUEST <= 1'b0;
      oa_prev_reg          <= 1'b0;
      fv_reg               <= 1'b0;
      comm_err_reg         <= 1'b0;
    end else begin
      state_reg            <= state_next;
      SAFETY_STATE         <= state_next;
      OPERATOR_ACK_REQUEST <= ack_req_next;
      comm_err_reg         <= ctrl_reg[`SCSM_CTRL_COMERR];
      if (frame_pulse_reg) begin
        oa_prev_reg <= frame_oa_reg;
        fv_reg      <= frame_fv_reg;
      end
    end
  end

  // Device watchdog restarts on each valid frame; expiry beats a budget-write clear, a frame in the same cycle beats expiry
  // The count saturates, so one silent spell raises the flag only once
  always @(posedge CORE_CLK) begin
    if (RESET) begin
      wd_count_reg     <= 32'h0000_0000;
      WATCHDOG_EXPIRED <= 1'b0;
    end else begin
      if (frame_pulse_reg)
        wd_count_reg <= 32'h0000_0000;
      else if (wd_count_reg != WD_CYCLES[31:0])
        wd_count_reg <= wd_count_reg + 32'h0000_0001;
      if (!frame_pulse_reg && wd_count_reg == WD_CYCLES[31:0] - 32'h0000_0001)
        WATCHDOG_EXPIRED <= 1'b1;
      else if (frame_pulse_reg || wd_time_pulse_reg)
        WATCHDOG_EXPIRED <= 1'b0;
    end
  end

  // Reply frame is issued next cycle, well inside the acknowledgement budget
  // The elapsed count advances only in the cycle after a frame, so it stops at 1 and cannot wrap
  always @(posedge CORE_CLK) begin
    if (RESET) begin
      reply_pending_reg  <= 1'b0;
      ack_count_reg      <= 32'h0000_0000;
      REPLY_FRAME_STROBE <= 1'b0;
    end else begin
      REPLY_FRAME_STROBE <= frame_pulse_reg;
      reply_pending_reg  <= frame_pulse_reg;
      if (frame_pulse_reg)
        ack_count_reg <= 32'h0000_0000;
      else if (reply_pending_reg && ack_count_reg != ACK_CYCLES[31:0])
        ack_count_reg <= ack_count_reg + 32'h0000_0001;
    end
  end

endmodule // scsm_core

// ===== verilog/scsm_consts.vh
// Constants for the safety communication state machine block
`ifndef SCSM_CONSTS_VH
`define SCSM_CONSTS_VH

// Register byte offsets
`define SCSM_OFF_CTRL     12'h000
`define SCSM_OFF_STATUS   12'h004
`define SCSM_OFF_FRAME    12'h008
`define SCSM_OFF_WDTIME   12'h00C

// Control register fields
`define SCSM_CTRL_REBOOT  0
`define SCSM_CTRL_FATAL   1
`define SCSM_CTRL_MOTOR   2
`define SCSM_CTRL_CFGTOOL 3
`define SCSM_CTRL_COMERR  4
`define SCSM_CTRL_SFERR   5
`define SCSM_CTRL_SFACK   6
`define SCSM_CTRL_BOOTOK  7

// Frame register fields (write = one received valid frame)
`define SCSM_FRM_OA       0
`define SCSM_FRM_FV       1

// State codes
`define SCSM_ST_STARTUP   3'h0
`define SCSM_ST_OPER      3'h1
`define SCSM_ST_PASSIV    3'h2
`define SCSM_ST_PASCMD    3'h3
`define SCSM_ST_REINT     3'h4
`define SCSM_ST_ACKREQ    3'h5
`define SCSM_ST_FAILSAFE  3'h6
`define SCSM_ST_CONFIG    3'h7

// Timing in ms, and clock rate in kHz
`define SCSM_DEV_WD_MS    50
`define SCSM_ACK_TIME_MS  50
`define SCSM_CLK_KHZ      100000

// AXI responses
`define SCSM_RESP_OKAY    2'h0
`define SCSM_RESP_SLVERR  2'h2

`endif

// ===== testbench/scsm_host_model.sv
// Safety controller side: connection watchdog budget chosen by the host
`timescale 1ns/100ps
module scsm_host_model #(
  parameter DEVICE_ACK_MS = 50,
  parameter HOST_ACK_MS   = 6,
  parameter BUS_MS        = 4,
  parameter ADAPTER_MS    = 3
) (
  output wire [31:0] wd_time_ms
);
  // Both bus legs carry the adapter delay
  localparam MIN_MS = DEVICE_ACK_MS + HOST_ACK_MS + 2 * (BUS_MS + ADAPTER_MS);
  // Headroom rounded up so the budget never lands on the minimum
  assign wd_time_ms = 32'((MIN_MS * 13 + 9) / 10);
endmodule // scsm_host_model

// ===== testbench/scsm_properties.sv
// Port-level assertions for the safety communication state machine
`timescale 1ns/100ps
`include "scsm_consts.vh"
module scsm_properties #(
  parameter WD_CYCLES  = 400,
  parameter ACK_CYCLES = 50
) (
  input wire        CORE_CLK,
  input wire        RESET,
  input wire [11:0] S_AXI_AWADDR,
  input wire        S_AXI_AWVALID,
  input wire        S_AXI_AWREADY,
  input wire [31:0] S_AXI_WDATA,
  input wire        S_AXI_WVALID,
  input wire        S_AXI_WREADY,
  input wire [1:0]  S_AXI_BRESP,
  input wire        S_AXI_BVALID,
  input wire [2:0]  SAFETY_STATE,
  input wire        REPLY_FRAME_STROBE,
  input wire        WATCHDOG_EXPIRED
);
  reg  [7:0]  ctrl_reg;
  reg  [31:0] idle_reg;
  wire        wr_hs;
  assign wr_hs = S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID && S_AXI_WREADY;
  // Shadow of the control word; the one-shot reboot bit is not kept
  always @(posedge CORE_CLK) begin
    if (RESET) begin
      ctrl_reg <= 8'h00;
      idle_reg <= 32'h0000_0000;
    end else begin
      if (wr_hs && S_AXI_AWADDR == `SCSM_OFF_CTRL) ctrl_reg <= S_AXI_WDATA[7:0] & 8'hFE;
      // Only a frame restarts the device watchdog; a budget write just clears the flag
      if (wr_hs && S_AXI_AWADDR == `SCSM_OFF_FRAME)
        idle_reg <= 32'h0000_0000;
      else
        idle_reg <= idle_reg + 32'h0000_0001;
    end
  end
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (RESET);
  a_config_exit_only: assert property (SAFETY_STATE == `SCSM_ST_CONFIG |=>
    SAFETY_STATE inside {`SCSM_ST_CONFIG, `SCSM_ST_STARTUP}) else $error("config left wrongly");
  a_config_entry: assert property (ctrl_reg[3] && !ctrl_reg[2] &&
    SAFETY_STATE != `SCSM_ST_CONFIG |-> ##[1:4] SAFETY_STATE == `SCSM_ST_CONFIG)
    else $error("config not entered");
  a_fatal_failsafe: assert property (ctrl_reg[1] && !ctrl_reg[3] &&
    SAFETY_STATE != `SCSM_ST_FAILSAFE |-> ##[1:4] SAFETY_STATE == `SCSM_ST_FAILSAFE)
    else $error("fatal error ignored");
  a_reply_after_frame: assert property (wr_hs && S_AXI_AWADDR == `SCSM_OFF_FRAME
    |-> ##[2:6] REPLY_FRAME_STROBE) else $error("no reply frame");
  a_reply_single: assert property (REPLY_FRAME_STROBE |=> !REPLY_FRAME_STROBE)
    else $error("reply strobe too long");
  a_wd_not_early: assert property ($rose(WATCHDOG_EXPIRED) |-> idle_reg >= WD_CYCLES - 1)
    else $error("watchdog expired early");
  a_wd_passivates: assert property (WATCHDOG_EXPIRED && SAFETY_STATE inside
    {`SCSM_ST_OPER, `SCSM_ST_REINT} |-> ##[0:3] SAFETY_STATE == `SCSM_ST_PASSIV)
    else $error("watchdog did not passivate");
  a_unmapped_write: assert property (wr_hs && S_AXI_AWADDR >= `SCSM_OFF_WDTIME + 12'h004
    |-> ##[1:3] S_AXI_BVALID && S_AXI_BRESP == `SCSM_RESP_SLVERR) else $error("bad bresp");
endmodule // scsm_properties

bind scsm_core scsm_properties #(.WD_CYCLES(WD_CYCLES), .ACK_CYCLES(ACK_CYCLES))
  i_scsm_properties (.CORE_CLK(CORE_CLK), .RESET(RESET), .S_AXI_AWADDR(S_AXI_AWADDR),
  .S_AXI_AWVALID(S_AXI_AWVALID), .S_AXI_AWREADY(S_AXI_AWREADY), .S_AXI_WDATA(S_AXI_WDATA),
  .S_AXI_WVALID(S_AXI_WVALID), .S_AXI_WREADY(S_AXI_WREADY), .S_AXI_BRESP(S_AXI_BRESP),
  .S_AXI_BVALID(S_AXI_BVALID), .SAFETY_STATE(SAFETY_STATE),
  .REPLY_FRAME_STROBE(REPLY_FRAME_STROBE), .WATCHDOG_EXPIRED(WATCHDOG_EXPIRED));

// ===== testbench/tb.sv
// Register-level bench for the safety communication state machine
`timescale 1ns/100ps
`include "scsm_consts.vh"
module tb;
  localparam WD = 400;
  reg         clk = 1'b0;
  reg         rst = 1'b1;
  reg  [11:0] awaddr = 12'h000, araddr = 12'h000;
  reg  [31:0] wdata = 32'h0000_0000;
  reg         awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  wire        awready, wready, bvalid, arready, rvalid, ack_req, strobe, wd_exp;
  wire [1:0]  bresp, rresp;
  wire [2:0]  state;
  wire [31:0] rdata, wd_time;
  reg  [1:0]  resp;
  reg  [31:0] val;
  integer     n_mismatch = 0, samples_checked = 0, i, n_reply = 0, n_frames = 0;

  scsm_host_model i_scsm_host_model (.wd_time_ms(wd_time));
  scsm_core #(.WD_CYCLES(WD), .ACK_CYCLES(50)) i_scsm_core (.CORE_CLK(clk), .RESET(rst),
    .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready),
    .S_AXI_WDATA(wdata), .S_AXI_WSTRB(4'hF), .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready),
    .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
    .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
    .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready),
    .SAFETY_STATE(state), .OPERATOR_ACK_REQUEST(ack_req), .REPLY_FRAME_STROBE(strobe),
    .WATCHDOG_EXPIRED(wd_exp));

  always #5 clk = ~clk;

  // Every received frame must be answered by exactly one reply strobe
  always @(posedge clk)
    if (strobe === 1'b1) n_reply <= n_reply + 1;

  task chk(input [63:0] what, input [31:0] exp, input [31:0] got);
    begin
      samples_checked = samples_checked + 1;
      if (got !== exp) begin
        n_mismatch = n_mismatch + 1;
        $display("MISMATCH %0s expected %h seen %h", what, exp, got);
      end
    end
  endtask

  task wr(input [11:0] a, input [31:0] d);
    integer n;
    begin
      n = 0;
      @(posedge clk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      while (n < 100) begin
        @(posedge clk);
        n = n + 1;
        if (awvalid && awready) awvalid <= 1'b0;
        if (wvalid && wready) wvalid <= 1'b0;
        if (bvalid) begin
          resp = bresp;
          bready <= 1'b0;
          n = 1000;
        end
      end
      if (n < 1000) chk("wr_wait", 0, 1);
    end
  endtask

  task rd(input [11:0] a);
    integer n;
    begin
      n = 0;
      @(posedge clk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      while (n < 100) begin
        @(posedge clk);
        n = n + 1;
        if (arvalid && arready) arvalid <= 1'b0;
        if (rvalid) begin
          val = rdata;
          resp = rresp;
          rready <= 1'b0;
          n = 1000;
        end
      end
      if (n < 1000) chk("rd_wait", 0, 1);
    end
  endtask

  // Four edges cover the frame pulse, the state update and a reboot's restart
  task st(input [11:0] a, input [31:0] d, input [2:0] e);
    begin
      wr(a, d);
      repeat (4) @(posedge clk);
      chk("state", {29'h0, e}, {29'h0, state});
    end
  endtask

  task fr(input [1:0] d, input [2:0] e);
    begin
      n_frames = n_frames + 1;
      st(`SCSM_OFF_FRAME, {30'h0, d}, e);
    end
  endtask

  task ct(input [7:0] d, input [2:0] e);
    st(`SCSM_OFF_CTRL, {24'h00_0000, d}, e);
  endtask

  task conclude;
    begin
      $display("compared %0d mismatched %0d", samples_checked, n_mismatch);
      if (n_mismatch == 0 && samples_checked > 0)
        $display("STATUS OK");
      else
        $display("STATUS NOT OK");
      $finish;
    end
  endtask

  initial begin
    #100000;
    n_mismatch = n_mismatch + 1;
    conclude;
  end

  initial begin
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    rd(`SCSM_OFF_CTRL);
    chk("ctrl", 0, val);
    rd(`SCSM_OFF_STATUS);
    chk("status", 0, val);
    chk("wdbudget", 32'h0000_005B, wd_time);
    wr(`SCSM_OFF_WDTIME, wd_time);
    rd(`SCSM_OFF_WDTIME);
    chk("wdtime", wd_time, val);
    wr(12'h010, 32'h0000_0000);
    chk("bresp", {30'h0, `SCSM_RESP_SLVERR}, {30'h0, resp});
    rd(12'h010);
    chk("rresp", {30'h0, `SCSM_RESP_SLVERR}, {30'h0, resp});
    // Fail-value held at 1 so start-up parks in passivation with command
    fr(2'b10, `SCSM_ST_STARTUP);
    ct(8'h80, `SCSM_ST_PASCMD);
    fr(2'b00, `SCSM_ST_OPER);
    ct(8'hA0, `SCSM_ST_REINT);
    fr(2'b10, `SCSM_ST_PASCMD);
    fr(2'b00, `SCSM_ST_REINT);
    ct(8'hB0, `SCSM_ST_PASSIV);
    wr(`SCSM_OFF_CTRL, 32'h0000_00A0);
    fr(2'b00, `SCSM_ST_ACKREQ);
    chk("ackreq", 1, {31'h0, ack_req});
    fr(2'b01, `SCSM_ST_REINT);
    ct(8'hC0, `SCSM_ST_REINT);
    ct(8'h80, `SCSM_ST_OPER);
    ct(8'h90, `SCSM_ST_PASSIV);
    wr(`SCSM_OFF_CTRL, 32'h0000_0080);
    fr(2'b01, `SCSM_ST_ACKREQ);
    fr(2'b01, `SCSM_ST_ACKREQ);
    fr(2'b00, `SCSM_ST_ACKREQ);
    fr(2'b01, `SCSM_ST_OPER);
    ct(8'h90, `SCSM_ST_PASSIV);
    wr(`SCSM_OFF_CTRL, 32'h0000_0080);
    fr(2'b00, `SCSM_ST_ACKREQ);
    fr(2'b10, `SCSM_ST_PASCMD);
    fr(2'b00, `SCSM_ST_ACKREQ);
    fr(2'b10, `SCSM_ST_PASCMD);
    ct(8'h01, `SCSM_ST_STARTUP);
    ct(8'h80, `SCSM_ST_PASCMD);
    ct(8'h82, `SCSM_ST_FAILSAFE);
    ct(8'h01, `SCSM_ST_STARTUP);
    ct(8'h0C, `SCSM_ST_STARTUP);
    ct(8'h08, `SCSM_ST_CONFIG);
    ct(8'h80, `SCSM_ST_CONFIG);
    ct(8'h81, `SCSM_ST_PASCMD);
    fr(2'b00, `SCSM_ST_OPER);
    repeat (WD - 20) @(posedge clk);
    chk("wd_early", 0, {31'h0, wd_exp});
    i = 0;
    while (wd_exp !== 1'b1 && i < 40) begin
      @(posedge clk);
      i = i + 1;
    end
    repeat (4) @(posedge clk);
    wr(`SCSM_OFF_STATUS, 32'h0000_0000);
    rd(`SCSM_OFF_STATUS);
    chk("status", 32'h0000_0022, val & 32'h0000_0027);
    fr(2'b00, `SCSM_ST_ACKREQ);
    chk("wd_flag", 0, {31'h0, wd_exp});
    chk("replies", n_frames, n_reply);
    conclude;
  end
endmodule // tb
